// ==== rtl/lfb_pkg.sv ====
// package for the lcd frame, blink and scroll control block
// assumes an 8-bit special-function register port and tick strobes from the lcd clock tree
package lfb_pkg;

	// special-function register addresses
	localparam logic [7:0] LFB_CLK_ADDR      = 8'h96;
	localparam logic [7:0] LFB_SCR_ADDR      = 8'hb1;
	localparam logic [7:0] LFB_CLK_RESET     = 8'h00;
	localparam logic [7:0] LFB_SCR_RESET     = 8'h00;

	// lcd_scroll_screen_control fields
	localparam int         LFB_SCR_AUTO      = 7;
	localparam int         LFB_SCR_INV       = 6;
	localparam int         LFB_SCR_SEL_LO    = 2;
	localparam int         LFB_SCR_DONE      = 1;
	localparam int         LFB_SCR_FREEZE    = 0;

	// lcd_blink_and_frame_clock fields
	localparam int         LFB_CLK_BSRC_LO   = 6;
	localparam int         LFB_CLK_BRATE_LO  = 4;
	localparam int         LFB_CLK_FD_LO     = 0;

	// blink_source codes
	localparam logic [1:0] LFB_BSRC_SW_OFF   = 2'h0;
	localparam logic [1:0] LFB_BSRC_SW_ON    = 2'h1;
	localparam logic [1:0] LFB_BSRC_FIXED    = 2'h2;

	// common_mux_level codes
	localparam logic [1:0] LFB_MUX_3X        = 2'h2;
	localparam logic [1:0] LFB_MUX_4X        = 2'h3;

	// blink pacing, counted in ticks of the slow lcd clock
	localparam int         LFB_SLOW_HZ       = 128;
	localparam int         LFB_FIXED_HZ      = 2;
	localparam logic [8:0] LFB_HALF_1HZ      = 9'(LFB_SLOW_HZ / 2);
	localparam logic [8:0] LFB_HALF_FIXED    = 9'(LFB_SLOW_HZ / (2 * LFB_FIXED_HZ));

	typedef struct packed {
		logic [1:0] screen;
		logic       blank;
		logic       invert;
	} lfb_disp_t;

	typedef enum logic [1:0] {UPD_RUN, UPD_FROZEN, UPD_PENDING} lfb_upd_t;

	// source ticks per drive period for each clock source, mux level and divider code
	function automatic logic [7:0] lfb_drive_div(input logic slow, input logic [1:0] mux,
			input logic [3:0] fd);
		logic wide;
		wide = (mux == LFB_MUX_3X) || (mux == LFB_MUX_4X);
		if (slow) begin
			if (fd == 4'h0)
				lfb_drive_div = 8'h02;
			else if (fd == 4'hf)
				lfb_drive_div = 8'h01;
			else if (wide)
				lfb_drive_div = 8'h04;
			else if (fd == 4'h1)
				lfb_drive_div = 8'h04;
			else if (fd == 4'h2)
				lfb_drive_div = 8'h06;
			else
				lfb_drive_div = 8'h08;
		end else if (fd == 4'h0) begin
			lfb_drive_div = wide ? 8'h40 : 8'h80;
		end else if (wide && fd == 4'h1) begin
			lfb_drive_div = (mux == LFB_MUX_3X) ? 8'h06 : 8'h04;
		end else if (wide && fd == 4'h2) begin
			lfb_drive_div = 8'h06;
		end else begin
			lfb_drive_div = wide ? {3'h0, fd, 1'b0} + 8'h02 : {2'h0, fd, 2'h0} + 8'h04;
		end
	endfunction : lfb_drive_div

	// drive periods per frame
	function automatic logic [2:0] lfb_frame_div(input logic [1:0] mux);
		case (mux)
			LFB_MUX_3X: lfb_frame_div = 3'h3;
			LFB_MUX_4X: lfb_frame_div = 3'h4;
			default:    lfb_frame_div = 3'h2;
		endcase
	endfunction : lfb_frame_div

endpackage : lfb_pkg

// ==== rtl/lfb_rate_div.sv ====
// drive-frequency and frame-rate divider
// assumes src_tick is a one-cycle strobe of the chosen lcd clock source
`timescale 1ns/1ps
module lfb_rate_div
	import lfb_pkg::*;
(
	// clock and control
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// divider setting
	input  wire logic       src_tick,
	input  wire logic [7:0] drive_div,
	input  wire logic [2:0] frame_div,
	// timing strobes
	output logic            drive_tick,
	output logic            frame_start
);

	logic [7:0] drv_cnt;
	logic [2:0] frm_cnt;
	logic [7:0] next_drv_cnt;
	logic [2:0] next_frm_cnt;
	logic       next_drive_tick;
	logic       next_frame_start;

	always_comb begin
		next_drv_cnt     = drv_cnt;
		next_frm_cnt     = frm_cnt;
		next_drive_tick  = 1'b0;
		next_frame_start = 1'b0;
		if (src_tick) begin
			if (drv_cnt >= drive_div - 8'h01) begin
				next_drv_cnt    = 8'h00;
				next_drive_tick = 1'b1;
				if (frm_cnt >= frame_div - 3'h1) begin
					next_frm_cnt     = 3'h0;
					next_frame_start = 1'b1;
				end else begin
					next_frm_cnt = frm_cnt + 3'h1;
				end
			end else begin
				next_drv_cnt = drv_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			drv_cnt     <= 8'h00;
			frm_cnt     <= 3'h0;
			drive_tick  <= 1'b0;
			frame_start <= 1'b0;
		end else if (ce) begin
			drv_cnt     <= next_drv_cnt;
			frm_cnt     <= next_frm_cnt;
			drive_tick  <= next_drive_tick;
			frame_start <= next_frame_start;
		end
	end

	frame_on_drive_a: assert property (@(posedge mclk) disable iff (!rst_n)
		frame_start |-> drive_tick)
		else $error("frame start without drive tick");

	drive_wrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && src_tick && drv_cnt >= drive_div - 8'h01) |=> (drive_tick && drv_cnt == 8'h00))
		else $error("drive divider did not wrap");

endmodule : lfb_rate_div

// ==== rtl/lfb_blink_tmr.sv ====
// blink and scroll pacing timer
// assumes slow_tick is a one-cycle strobe of the 128 Hz lcd clock
`timescale 1ns/1ps
module lfb_blink_tmr
	import lfb_pkg::*;
(
	// clock and control
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// pacing
	input  wire logic       slow_tick,
	input  wire logic [8:0] half_len,
	// results
	output logic            phase,
	output logic            period_end
);

	logic [8:0] cnt;
	logic [8:0] next_cnt;
	logic       next_phase;
	logic       next_period_end;

	always_comb begin
		next_cnt        = cnt;
		next_phase      = phase;
		next_period_end = 1'b0;
		if (slow_tick) begin
			// one half period per phase, so a full blink takes two
			if (cnt >= half_len - 9'h001) begin
				next_cnt        = 9'h000;
				next_phase      = !phase;
				next_period_end = phase;
			end else begin
				next_cnt = cnt + 9'h001;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cnt        <= 9'h000;
			phase      <= 1'b0;
			period_end <= 1'b0;
		end else if (ce) begin
			cnt        <= next_cnt;
			phase      <= next_phase;
			period_end <= next_period_end;
		end
	end

	period_phase_a: assert property (@(posedge mclk) disable iff (!rst_n)
		period_end |-> !phase)
		else $error("period end while phase high");

	half_toggle_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && slow_tick && cnt >= half_len - 9'h001) |=> (phase != $past(phase)))
		else $error("phase did not toggle at half period");

endmodule : lfb_blink_tmr

// ==== rtl/lfb_ctrl.sv ====
// lcd frame, blink and scroll control: registers, update handshake, presentation
// assumes a byte-wide special-function register port and tick strobes from the lcd clock tree
`timescale 1ns/1ps
module lfb_ctrl
	import lfb_pkg::*;
(
	// clock and control
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// special-function register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	output logic      [7:0] sfr_rdata,
	// settings held in the main lcd configuration register
	input  wire logic       blink_on,
	input  wire logic       lcd_clock_source,
	input  wire logic [1:0] common_mux_level,
	// lcd clock source strobes
	input  wire logic       tick_2048,
	input  wire logic       tick_128,
	// display side
	output lfb_disp_t       disp,
	output logic            display_load,
	output logic            drive_tick,
	output logic            frame_start
);

	logic [7:0] clk_reg;
	logic       scr_auto;
	logic       scr_inv;
	logic [1:0] scr_sel;
	logic       scr_done;
	logic       scr_freeze;
	logic       invert;
	logic       blank;
	logic       step_pend;
	lfb_upd_t   upd_state;

	logic [7:0] next_clk_reg;
	logic       next_scr_auto;
	logic       next_scr_inv;
	logic [1:0] next_scr_sel;
	logic       next_scr_done;
	logic       next_scr_freeze;
	logic       next_invert;
	logic       next_blank;
	logic       next_step_pend;
	logic       next_display_load;
	logic [7:0] next_sfr_rdata;
	lfb_upd_t   next_upd_state;

	logic       wr_clk;
	logic       wr_scr;
	logic [1:0] blink_src;
	logic [1:0] blink_rate;
	logic [8:0] half_len;
	logic       blink_phase;
	logic       blink_period_end;
	logic       src_tick;

	assign wr_clk     = sfr_wr && sfr_addr == LFB_CLK_ADDR;
	assign wr_scr     = sfr_wr && sfr_addr == LFB_SCR_ADDR;
	assign blink_src  = clk_reg[LFB_CLK_BSRC_LO +: 2];
	assign blink_rate = clk_reg[LFB_CLK_BRATE_LO +: 2];
	assign src_tick   = lcd_clock_source ? tick_128 : tick_2048;

	assign half_len = (!scr_auto && blink_src == LFB_BSRC_FIXED) ? LFB_HALF_FIXED :
		9'(LFB_HALF_1HZ * ({7'h00, blink_rate} + 9'h001));

	lfb_rate_div u_rate (
		.mclk        (mclk),
		.rst_n       (rst_n),
		.ce          (ce),
		.src_tick    (src_tick),
		.drive_div   (lfb_drive_div(lcd_clock_source, common_mux_level,
			clk_reg[LFB_CLK_FD_LO +: 4])),
		.frame_div   (lfb_frame_div(common_mux_level)),
		.drive_tick  (drive_tick),
		.frame_start (frame_start)
	);

	lfb_blink_tmr u_blink (
		.mclk       (mclk),
		.rst_n      (rst_n),
		.ce         (ce),
		.slow_tick  (tick_128),
		.half_len   (half_len),
		.phase      (blink_phase),
		.period_end (blink_period_end)
	);

	// register file and read port
	always_comb begin
		next_clk_reg    = clk_reg;
		next_scr_auto   = scr_auto;
		next_scr_inv    = scr_inv;
		next_scr_sel    = scr_sel;
		next_scr_freeze = scr_freeze;
		next_scr_done   = scr_done;
		next_sfr_rdata  = sfr_rdata;
		if (wr_clk)
			next_clk_reg = sfr_wdata;
		if (wr_scr) begin
			next_scr_auto   = sfr_wdata[LFB_SCR_AUTO];
			next_scr_inv    = sfr_wdata[LFB_SCR_INV];
			next_scr_freeze = sfr_wdata[LFB_SCR_FREEZE];
			if (!sfr_wdata[LFB_SCR_DONE])
				next_scr_done = 1'b0;
		end
		if (scr_auto && frame_start && (step_pend || blink_period_end))
			next_scr_sel = scr_sel + 2'h1;
		if (wr_scr)
			next_scr_sel = sfr_wdata[LFB_SCR_SEL_LO +: 2];
		// hardware set wins over a software clear
		if (next_display_load)
			next_scr_done = 1'b1;
		if (sfr_rd) begin
			case (sfr_addr)
				LFB_CLK_ADDR: next_sfr_rdata = clk_reg;
				// reserved bits 5:4 read as zero
				LFB_SCR_ADDR: next_sfr_rdata = {scr_auto, scr_inv, 2'h0, scr_sel, scr_done,
					scr_freeze};
				default:      next_sfr_rdata = 8'h00;
			endcase
		end
	end

	// update handshake with display memory writes
	always_comb begin
		next_upd_state    = upd_state;
		next_display_load = 1'b0;
		case (upd_state)
			UPD_RUN: begin
				if (scr_freeze)
					next_upd_state = UPD_FROZEN;
				else if (frame_start)
					next_display_load = 1'b1;
			end
			UPD_FROZEN: begin
				if (!scr_freeze)
					next_upd_state = UPD_PENDING;
			end
			UPD_PENDING: begin
				if (scr_freeze) begin
					next_upd_state = UPD_FROZEN;
				end else if (frame_start) begin
					next_display_load = 1'b1;
					next_upd_state    = UPD_RUN;
				end
			end
			default: next_upd_state = UPD_RUN;
		endcase
	end

	// presentation: scroll pacing, blink blanking, frame inversion
	always_comb begin
		next_step_pend = step_pend;
		if (!scr_auto || frame_start)
			next_step_pend = 1'b0;
		else if (blink_period_end)
			next_step_pend = 1'b1;
		if (!scr_inv)
			next_invert = 1'b0;
		else if (frame_start)
			next_invert = !invert;
		else
			next_invert = invert;
		// scrolling suppresses blinking
		if (!blink_on || scr_auto) begin
			next_blank = 1'b0;
		end else begin
			case (blink_src)
				LFB_BSRC_SW_OFF: next_blank = 1'b1;
				LFB_BSRC_SW_ON:  next_blank = 1'b0;
				default:         next_blank = blink_phase;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			clk_reg      <= LFB_CLK_RESET;
			scr_auto     <= LFB_SCR_RESET[LFB_SCR_AUTO];
			scr_inv      <= LFB_SCR_RESET[LFB_SCR_INV];
			scr_sel      <= LFB_SCR_RESET[LFB_SCR_SEL_LO +: 2];
			scr_done     <= LFB_SCR_RESET[LFB_SCR_DONE];
			scr_freeze   <= LFB_SCR_RESET[LFB_SCR_FREEZE];
			sfr_rdata    <= 8'h00;
			upd_state    <= UPD_RUN;
			display_load <= 1'b0;
			step_pend    <= 1'b0;
			invert       <= 1'b0;
			blank        <= 1'b0;
		end else if (ce) begin
			clk_reg      <= next_clk_reg;
			scr_auto     <= next_scr_auto;
			scr_inv      <= next_scr_inv;
			scr_sel      <= next_scr_sel;
			scr_done     <= next_scr_done;
			scr_freeze   <= next_scr_freeze;
			sfr_rdata    <= next_sfr_rdata;
			upd_state    <= next_upd_state;
			display_load <= next_display_load;
			step_pend    <= next_step_pend;
			invert       <= next_invert;
			blank        <= next_blank;
		end
	end

	assign disp = '{screen: scr_sel, blank: blank, invert: invert};

	scroll_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && scr_auto && frame_start && step_pend && !wr_scr) |=> scr_sel == $past(scr_sel) + 2'h1)
		else $error("auto scroll did not advance screen");

	scroll_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && !frame_start && !wr_scr) |=> scr_sel == $past(scr_sel))
		else $error("screen changed outside frame boundary");

	scroll_noblink_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && scr_auto) |=> !blank)
		else $error("blinking while scrolling");

	invert_alt_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && scr_inv && frame_start) |=> invert != $past(invert))
		else $error("frame inversion did not alternate");

	no_invert_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && !scr_inv) |=> !invert)
		else $error("inverted frame while inversion off");

	screen_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && wr_scr) |=> disp.screen == $past(sfr_wdata[3:2]))
		else $error("written screen index not shown");

	done_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
		display_load |-> scr_done)
		else $error("update done flag missing after load");

	freeze_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && scr_freeze) |=> !display_load)
		else $error("display loaded while frozen");

	unfreeze_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && upd_state == UPD_PENDING && !scr_freeze && frame_start) |=> display_load)
		else $error("no load at frame after unfreeze");

	blink_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && blink_on && !scr_auto && blink_src == LFB_BSRC_SW_OFF) |=> blank)
		else $error("display not blanked in software-off blink");

	blink_phase_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && blink_on && !scr_auto && blink_src[1]) |=> blank == $past(blink_phase))
		else $error("blank does not follow blink phase");

	freeze_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && wr_scr) |=> scr_freeze == $past(sfr_wdata[LFB_SCR_FREEZE]))
		else $error("freeze bit not taken from write");

	done_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && wr_scr && !sfr_wdata[LFB_SCR_DONE] && !next_display_load) |=> !scr_done)
		else $error("update done flag not cleared by write");

	clk_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && sfr_rd && sfr_addr == LFB_CLK_ADDR) |=> sfr_rdata == $past(clk_reg))
		else $error("clock register read back wrong");

	freeze_c: cover property (@(posedge mclk) disable iff (!rst_n)
		scr_freeze && frame_start);

	scroll_wrap_c: cover property (@(posedge mclk) disable iff (!rst_n)
		scr_auto && scr_sel == 2'h3 ##[1:1000] scr_sel == 2'h0);

	unfreeze_c: cover property (@(posedge mclk) disable iff (!rst_n)
		upd_state == UPD_PENDING ##[1:300] display_load);

	blink_c: cover property (@(posedge mclk) disable iff (!rst_n)
		blink_on && !scr_auto && $rose(blank));

endmodule : lfb_ctrl

// ==== tb/lfb_glass.sv ====
// lcd glass model: watches drive strobes and presentation, measures periods
// assumes src_tick and slow_tick are strobes spaced at least two mclk apart
`timescale 1ns/1ps
module lfb_glass
	import lfb_pkg::*;
(
	// clock
	input  wire logic        mclk,
	// drive side
	input  wire logic        src_tick,
	input  wire logic        slow_tick,
	input  wire lfb_disp_t   disp,
	input  wire logic        display_load,
	input  wire logic        drive_tick,
	input  wire logic        frame_start,
	// measurements
	output logic      [15:0] period,
	output logic      [15:0] frame_len,
	output logic      [15:0] half_len,
	output logic      [15:0] step_len,
	output logic      [15:0] loads,
	output logic      [15:0] blinks,
	output logic      [15:0] steps,
	output logic      [15:0] bad_steps
);
	logic [15:0] scnt = '0, dcnt = '0, bcnt = '0, tcnt = '0;
	lfb_disp_t   disp_q = '0;
	logic        fs_q = 1'b0;

	initial begin
		{period, frame_len, half_len, step_len, loads, blinks, steps, bad_steps} = '0;
	end

	always @(posedge mclk) begin
		fs_q   <= frame_start;
		disp_q <= disp;
		if (drive_tick) begin
			period <= scnt;
			// a tick in the same cycle opens the next count
			scnt   <= {15'h0, src_tick};
		end else if (src_tick)
			scnt <= scnt + 16'h1;
		if (frame_start) begin
			frame_len <= dcnt + 16'h1;
			dcnt      <= '0;
		end else if (drive_tick)
			dcnt <= dcnt + 16'h1;
		if (display_load)
			loads <= loads + 16'h1;
		if (disp.blank !== disp_q.blank) begin
			half_len <= bcnt;
			bcnt     <= {15'h0, slow_tick};
			blinks   <= blinks + 16'h1;
		end else if (slow_tick)
			bcnt <= bcnt + 16'h1;
		// a screen change must follow a frame start by one cycle
		if (disp.screen !== disp_q.screen) begin
			step_len <= tcnt;
			tcnt     <= {15'h0, slow_tick};
			steps    <= steps + 16'h1;
			if (fs_q !== 1'b1)
				bad_steps <= bad_steps + 16'h1;
		end else if (slow_tick)
			tcnt <= tcnt + 16'h1;
	end
endmodule : lfb_glass

// ==== tb/test_lfb_ctrl.sv ====
// testbench for the lcd frame, blink and scroll control block
// assumes the glass model beside it; lcd clock strobes are made here, faster than real
`timescale 1ns/1ps
module test_lfb_ctrl
	import lfb_pkg::*;
;
	logic        mclk = 1'b0, rst_n, ce, sfr_wr, sfr_rd, blink_on, lcd_clock_source;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rd;
	logic [1:0]  common_mux_level, tdiv = 2'h0;
	logic        tick_2048 = 1'b0, tick_128 = 1'b0, display_load, drive_tick, frame_start;
	logic        src_tick;
	lfb_disp_t   disp;
	logic [15:0] period, frame_len, half_len, step_len, loads, blinks, steps, bad_steps, m0;
	int          errors = 0, comparisons = 0;

	assign src_tick = lcd_clock_source ? tick_128 : tick_2048;

	lfb_ctrl i_dut (.mclk, .rst_n, .ce, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
		.blink_on, .lcd_clock_source, .common_mux_level, .tick_2048, .tick_128, .disp,
		.display_load, .drive_tick, .frame_start);
	lfb_glass i_glass (.mclk, .src_tick, .slow_tick(tick_128), .disp, .display_load,
		.drive_tick, .frame_start, .period, .frame_len, .half_len, .step_len, .loads,
		.blinks, .steps, .bad_steps);

	always #12.5 mclk = ~mclk;

	// fast source strobe every 4 cycles, slow strobe every 2
	always @(posedge mclk) begin
		tdiv      <= tdiv + 2'h1;
		tick_128  <= tdiv[0];
		tick_2048 <= (tdiv == 2'h0);
	end

	task automatic complete_run;
		$display("counts: %0d comparisons, %0d errors", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t: byte %h, expected %h", $time, got, exp);
		end
	endtask : chk_byte

	task automatic chk_num(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t: value %0d, expected %0d", $time, got, exp);
		end
	endtask : chk_num

	task automatic fail_wait;
		errors++;
		$display("ERROR at %0t: wait ran out", $time);
		complete_run;
	endtask : fail_wait

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		sfr_addr  <= a;
		sfr_wdata <= d;
		sfr_wr    <= 1'b1;
		@(posedge mclk);
		sfr_wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		sfr_addr <= a;
		sfr_rd   <= 1'b1;
		@(posedge mclk);
		sfr_rd <= 1'b0;
		#1;
		d = sfr_rdata;
	endtask : reg_rd

	task automatic wait_frame;
		for (int i = 0; i < 4000; i++) begin
			@(posedge mclk);
			#1;
			if (frame_start === 1'b1)
				return;
		end
		fail_wait;
	endtask : wait_frame

	task automatic wait_cnt(input bit scr, input logic [15:0] target);
		for (int i = 0; i < 6000; i++) begin
			@(posedge mclk);
			#1;
			if ((scr ? steps : blinks) === target)
				return;
		end
		fail_wait;
	endtask : wait_cnt

	task automatic rate(input logic src, input logic [1:0] mux, input logic [3:0] fd,
			input logic [15:0] div, input logic [15:0] frm);
		@(posedge mclk);
		lcd_clock_source <= src;
		common_mux_level <= mux;
		reg_wr(LFB_CLK_ADDR, {4'h0, fd});
		repeat (3) wait_frame;
		chk_num(period, div);
		chk_num(frame_len, frm);
	endtask : rate

	task automatic t_regs;
		reg_rd(LFB_CLK_ADDR, rd);
		chk_byte(rd, 8'h00);
		reg_rd(LFB_SCR_ADDR, rd);
		chk_byte(rd & 8'hfd, 8'h00);
		reg_wr(8'h55, 8'hff);
		reg_rd(8'h55, rd);
		chk_byte(rd, 8'h00);
		reg_wr(LFB_CLK_ADDR, 8'ha5);
		ce <= 1'b0;
		reg_wr(LFB_CLK_ADDR, 8'h00);
		ce <= 1'b1;
		reg_rd(LFB_CLK_ADDR, rd);
		chk_byte(rd, 8'ha5);
		reg_wr(LFB_SCR_ADDR, 8'h0c);
		reg_rd(LFB_SCR_ADDR, rd);
		chk_byte(rd & 8'hfd, 8'h0c);
		for (int s = 0; s < 4; s++) begin
			reg_wr(LFB_SCR_ADDR, {4'h0, 2'(s), 2'h0});
			#1;
			chk_num(16'(disp.screen), 16'(s));
		end
		$display("test registers done");
	endtask : t_regs

	task automatic t_rates;
		rate(1'b0, 2'h1, 4'h0, 16'h80, 16'h2);
		rate(1'b0, 2'h1, 4'h1, 16'h08, 16'h2);
		rate(1'b0, 2'h1, 4'hf, 16'h40, 16'h2);
		rate(1'b0, 2'h2, 4'h1, 16'h06, 16'h3);
		rate(1'b0, 2'h2, 4'h2, 16'h06, 16'h3);
		rate(1'b0, 2'h2, 4'h7, 16'h10, 16'h3);
		rate(1'b0, 2'h3, 4'h1, 16'h04, 16'h4);
		rate(1'b0, 2'h3, 4'h0, 16'h40, 16'h4);
		rate(1'b1, 2'h1, 4'h0, 16'h02, 16'h2);
		rate(1'b1, 2'h1, 4'h2, 16'h06, 16'h2);
		rate(1'b1, 2'h1, 4'h5, 16'h08, 16'h2);
		rate(1'b1, 2'h2, 4'h5, 16'h04, 16'h3);
		rate(1'b1, 2'h1, 4'hf, 16'h01, 16'h2);
		$display("test frame rates done");
	endtask : t_rates

	task automatic t_update;
		reg_wr(LFB_SCR_ADDR, 8'h01);
		wait_frame;
		reg_wr(LFB_SCR_ADDR, 8'h01);
		m0 = loads;
		repeat (4) wait_frame;
		chk_num(loads, m0);
		reg_rd(LFB_SCR_ADDR, rd);
		chk_byte(rd, 8'h01);
		reg_wr(LFB_SCR_ADDR, 8'h00);
		wait_frame;
		@(posedge mclk);
		#1;
		chk_num(16'(display_load), 16'h1);
		reg_rd(LFB_SCR_ADDR, rd);
		chk_byte(rd, 8'h02);
		reg_wr(LFB_SCR_ADDR, 8'h40);
		wait_frame;
		@(posedge mclk);
		#1;
		m0 = 16'(disp.invert);
		wait_frame;
		@(posedge mclk);
		#1;
		chk_num(16'(disp.invert), m0 ^ 16'h1);
		reg_wr(LFB_SCR_ADDR, 8'h0c);
		repeat (3) wait_frame;
		chk_num(16'(disp.invert), 16'h0);
		$display("test update and invert done");
	endtask : t_update

	task automatic t_blink;
		@(posedge mclk);
		blink_on <= 1'b1;
		for (int s = 0; s < 2; s++) begin
			reg_wr(LFB_CLK_ADDR, {2'(s), 6'h0f});
			repeat (4) @(posedge mclk);
			#1;
			chk_num(16'(disp.blank), 16'(1 - s));
		end
		reg_wr(LFB_CLK_ADDR, 8'h8f);
		wait_cnt(1'b0, blinks + 16'h3);
		chk_num(half_len, 16'h20);
		for (int k = 0; k < 4; k++) begin
			reg_wr(LFB_CLK_ADDR, {2'h3, 2'(k), 4'hf});
			wait_cnt(1'b0, blinks + 16'h3);
			chk_num(half_len, 16'(64 * (k + 1)));
		end
		@(posedge mclk);
		blink_on <= 1'b0;
		repeat (4) @(posedge mclk);
		#1;
		chk_num(16'(disp.blank), 16'h0);
		$display("test blink done");
	endtask : t_blink

	task automatic t_scroll;
		@(posedge mclk);
		blink_on <= 1'b1;
		reg_wr(LFB_CLK_ADDR, 8'hcf);
		reg_wr(LFB_SCR_ADDR, 8'h8c);
		m0 = bad_steps;
		for (int i = 0; i < 4; i++) begin
			wait_cnt(1'b1, steps + 16'h1);
			chk_num(16'(disp.screen), 16'(i));
		end
		chk_num(16'(step_len >= 16'h7e && step_len <= 16'h82), 16'h1);
		chk_num(bad_steps, m0);
		chk_num(16'(disp.blank), 16'h0);
		$display("test scroll done");
	endtask : t_scroll

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		blink_on = 1'b0;
		lcd_clock_source = 1'b0;
		common_mux_level = 2'h1;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		t_regs;
		t_rates;
		t_update;
		t_blink;
		t_scroll;
		complete_run;
	end
endmodule : test_lfb_ctrl
